// >>> design/trbf_pkg.sv
package trbf_pkg;

  // ----------------------------------------------------------------
  // Block forming constants
  // ----------------------------------------------------------------
  localparam int unsigned BLOCK_CHARS = 86;
  localparam int unsigned CHAR_WIDTH  = 8;
  localparam int unsigned FIFO_DEPTH  = 16;

  // Control characters decoded on the seven data bits
  localparam logic [6:0] CHAR_CR  = 7'h0D;
  localparam logic [6:0] CHAR_ETX = 7'h03;

  // Position of the eighth bit within a character
  localparam int unsigned BIT8_POS = 7;

  // ----------------------------------------------------------------
  // Register map of the plain register port
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [3:0] REG_COUNT   = 4'h2;
  localparam logic [3:0] REG_BLOCKS  = 4'h3;

  // Control field positions
  localparam int unsigned CTL_CONTINUOUS_BLOCK_FORMAT_POS   = 0;
  localparam int unsigned CTL_OPT_LSB    = 1;
  localparam int unsigned CTL_ENABLE_POS = 3;

  // Control reset value: line format, standard option, disabled
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Strapped option codes held in control bits 2:1
  typedef enum logic [1:0] {
    TRBF_OPT_STD_NOETX = 2'h0,
    TRBF_OPT_STD_ETX   = 2'h1,
    TRBF_OPT_BINARY    = 2'h2
  } trbf_opt_type;

  // Block former states
  typedef enum logic [1:0] {
    TRBF_FILL,
    TRBF_SEND,
    TRBF_MARK
  } trbf_state_type;

endpackage

// >>> design/trbf_fifo.sv
`timescale 1ns/1ps
module trbf_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             out_full;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_fill;
  logic             next_out_full;
  logic             push;
  logic             pop;
  logic             load;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  assign out_valid = out_full;
  assign pop       = out_full && out_ready;
  // Output register takes a word when empty or being drained
  assign load      = (fill != '0) && (!out_full || pop);

  // Pointer and fill next values
  always_comb begin
    next_wr_ptr   = wr_ptr;
    next_rd_ptr   = rd_ptr;
    next_fill     = fill;
    next_out_full = out_full;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
    end
    if (load) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
    end
    if (load) begin
      next_out_full = 1'b1;
    end else if (pop) begin
      next_out_full = 1'b0;
    end
    next_fill = fill + (AW+1)'(push) - (AW+1)'(load);
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      fill     <= '0;
      out_full <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      fill     <= next_fill;
      out_full <= next_out_full;
    end
  end

  // Storage and registered read data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
    if (load) begin
      out_data <= mem[rd_ptr];
    end
  end

endmodule

// >>> design/trbf_framer.sv
`timescale 1ns/1ps
module trbf_framer
  import trbf_pkg::*;
#(
  parameter int unsigned BLOCK_LEN = BLOCK_CHARS,
  parameter int unsigned DEPTH     = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // Characters from line or keyboard
  input  wire logic        char_valid,
  output logic             char_ready,
  input  wire logic [7:0]  char_data,
  // Characters to tape read/write control
  output logic             tape_valid,
  input  wire logic        tape_ready,
  output logic      [7:0]  tape_data,
  output logic             tape_last
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]       control;
  logic [7:0]       next_control;
  logic [7:0]       rdata;
  logic [7:0]       next_rdata;
  logic [7:0]       count;
  logic [7:0]       next_count;
  logic [7:0]       blocks;
  logic [7:0]       next_blocks;
  trbf_state_type   state;
  trbf_state_type   next_state;
  logic             continuous_block_format_fmt;
  logic             enable;
  trbf_opt_type     opt;
  logic             binary_mode;
  logic             etx_mode;
  logic [7:0]       shaped;
  logic             ends_block;
  logic             f_in_valid;
  logic             f_in_ready;
  logic [8:0]       f_out_data;
  logic             f_out_valid;
  logic             f_out_ready;
  logic             accept;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign continuous_block_format_fmt = control[CTL_CONTINUOUS_BLOCK_FORMAT_POS];
  assign enable   = control[CTL_ENABLE_POS];
  assign opt      = trbf_opt_type'(control[CTL_OPT_LSB +: 2]);
  // Strap options only matter in continuous format
  assign binary_mode = continuous_block_format_fmt && (opt == TRBF_OPT_BINARY);
  assign etx_mode    = continuous_block_format_fmt && (opt == TRBF_OPT_STD_ETX);

  // Is this character a block terminator in the current mode
  function automatic logic is_term(input logic [7:0] ch, input logic cf,
                                   input logic etx, input logic bin);
    logic [6:0] low;
    low = ch[6:0];
    if (bin) begin
      is_term = 1'b0;
    end else if (!cf) begin
      is_term = (low == CHAR_CR);
    end else if (etx) begin
      is_term = (low == CHAR_ETX);
    end else begin
      is_term = 1'b0;
    end
  endfunction

  // Eighth-bit shaping of a character before buffering
  always_comb begin
    shaped = char_data;
    if (!binary_mode) begin
      // Seven bits plus parity position, forced zero unless terminator kept
      shaped[BIT8_POS] = 1'b0;
      if (!continuous_block_format_fmt && char_data[6:0] == CHAR_CR) begin
        shaped[BIT8_POS] = char_data[BIT8_POS];
      end
      if (etx_mode && char_data[6:0] == CHAR_ETX) begin
        shaped[BIT8_POS] = char_data[BIT8_POS];
      end
    end
    // Binary keeps all eight bits as received
  end

  assign ends_block = is_term(char_data, continuous_block_format_fmt, etx_mode, binary_mode)
                      || (count == 8'(BLOCK_LEN - 1));

  // ----------------------------------------------------------------
  // Block former: characters stored until block full or terminated
  // ----------------------------------------------------------------
  assign f_in_valid = char_valid && enable && (state == TRBF_FILL);
  assign char_ready = f_in_ready && enable && (state == TRBF_FILL);
  assign accept     = f_in_valid && f_in_ready;

  // Next state and counters
  always_comb begin
    next_state  = state;
    next_count  = count;
    next_blocks = blocks;
    case (state)
      TRBF_FILL: begin
        if (accept) begin
          if (ends_block) begin
            next_state = TRBF_SEND;
            next_count = 8'(count + 8'h01);
          end else begin
            next_count = 8'(count + 8'h01);
          end
        end
      end
      TRBF_SEND: begin
        // Block is released as its last character leaves the buffer
        if (f_out_valid && f_out_ready && f_out_data[8]) begin
          next_state = TRBF_MARK;
        end
      end
      TRBF_MARK: begin
        next_count  = 8'h00;
        next_blocks = 8'(blocks + 8'h01);
        next_state  = TRBF_FILL;
      end
      default: begin
        next_state = TRBF_FILL;
      end
    endcase
  end

  // Buffer output gated: nothing recorded until the block is complete
  assign tape_valid  = f_out_valid && (state == TRBF_SEND);
  assign f_out_ready = tape_ready && (state == TRBF_SEND);
  assign tape_data   = f_out_data[7:0];
  assign tape_last   = f_out_data[8];

  trbf_fifo #(
    .WIDTH (9),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   ({ends_block, shaped}),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_comb begin
    next_control = control;
    next_rdata   = 8'h00;
    if (reg_write && reg_addr == REG_CONTROL) begin
      next_control = reg_wdata & 8'h0F;
      // Binary and end-of-text straps cannot coexist: code 3 falls to standard
      if (reg_wdata[CTL_OPT_LSB +: 2] == 2'h3) begin
        next_control[CTL_OPT_LSB +: 2] = TRBF_OPT_STD_NOETX;
      end
    end
    if (reg_read) begin
      case (reg_addr)
        REG_CONTROL: next_rdata = control;
        REG_STATUS:  next_rdata = {5'h00, f_out_valid, state == TRBF_SEND,
                                   f_in_ready};
        REG_COUNT:   next_rdata = count;
        REG_BLOCKS:  next_rdata = blocks;
        default:     next_rdata = 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata;

  // State registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      control <= CONTROL_RESET;
      rdata   <= 8'h00;
      count   <= 8'h00;
      blocks  <= 8'h00;
      state   <= TRBF_FILL;
    end else begin
      control <= next_control;
      rdata   <= next_rdata;
      count   <= next_count;
      blocks  <= next_blocks;
      state   <= next_state;
    end
  end

endmodule

// >>> dv/trbf_monitor.sv
`timescale 1ns/1ps
module trbf_monitor
  import trbf_pkg::*;
#(
  parameter int unsigned BLOCK_LEN = BLOCK_CHARS
) (
  // Clock, reset and register port
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // Character streams
  input wire logic       char_valid,
  input wire logic       char_ready,
  input wire logic [7:0] char_data,
  input wire logic       tape_valid,
  input wire logic       tape_ready,
  input wire logic [7:0] tape_data,
  input wire logic       tape_last
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [7:0] ctl, next_ctl, n_in, next_n_in, n_out, next_n_out;
  logic       term, bin, take, pop;
  // Control copy, fill count and drain count
  always_comb begin
    take = char_valid && char_ready;
    pop = tape_valid && tape_ready;
    bin = ctl[0] && ctl[2:1] == 2'h2;
    term = ctl[0] ? (ctl[2:1] == 2'h1 && tape_data[6:0] == CHAR_ETX) : tape_data[6:0] == CHAR_CR;
    next_ctl = ctl;
    if (reg_write && reg_addr == REG_CONTROL) begin
      next_ctl = {4'h0, reg_wdata[3], (reg_wdata[2:1] == 2'h3) ? 2'h0 : reg_wdata[2:1], reg_wdata[0]};
    end
    next_n_in = (pop && tape_last) ? 8'h00 : n_in + 8'(take);
    next_n_out = pop ? (tape_last ? 8'h00 : n_out + 8'h01) : n_out;
  end
  // Register the helper state
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctl <= CONTROL_RESET;
      n_in <= 8'h00;
      n_out <= 8'h00;
    end else begin
      ctl <= next_ctl;
      n_in <= next_n_in;
      n_out <= next_n_out;
    end
  end
  sequence blk_full;
    take && n_in == BLOCK_LEN - 1;
  endsequence
  chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  chk_control_read: assert property (reg_read && reg_addr == REG_CONTROL |=> reg_rdata == ctl)
    else $error("control readback wrong");
  chk_unmapped_zero: assert property (reg_read && reg_addr > REG_BLOCKS |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_disabled_refuse: assert property (!ctl[3] |-> !char_ready)
    else $error("character taken while disabled");
  chk_send_refuse: assert property (tape_valid |-> !char_ready)
    else $error("character taken while sending");
  chk_bit8_clear: assert property (tape_valid && !bin && !term |-> !tape_data[7])
    else $error("eighth bit not cleared");
  chk_term_last: assert property (tape_valid && term |-> tape_last)
    else $error("terminator not last of block");
  chk_block_len: assert property (pop && tape_last && !term |-> n_out == BLOCK_LEN - 1)
    else $error("block length wrong");
  chk_full_sends: assert property (blk_full |-> ##[1:3] tape_valid)
    else $error("full block not sent");
  chk_hold_stall: assert property (tape_valid && !tape_ready |=> tape_valid && $stable(tape_data))
    else $error("tape word dropped while stalled");
  chk_refill: assert property (pop && tape_last |-> ##[1:4] (char_ready || !ctl[3]))
    else $error("input not reopened after block");
endmodule
bind trbf_framer trbf_monitor #(.BLOCK_LEN(BLOCK_LEN)) u_monitor (.mclk(mclk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .char_valid(char_valid), .char_ready(char_ready),
  .char_data(char_data), .tape_valid(tape_valid), .tape_ready(tape_ready),
  .tape_data(tape_data), .tape_last(tape_last));

// >>> dv/trbf_tape_model.sv
`timescale 1ns/1ps
module trbf_tape_model (
  // Clock and stall pattern
  input wire logic       mclk,
  input wire logic [7:0] stall,
  // Tape side of the framer
  input wire logic       tape_valid,
  output logic           tape_ready,
  input wire logic [7:0] tape_data,
  input wire logic       tape_last,
  // Words taken by the transport
  output logic           obs_valid,
  output logic     [8:0] obs_word
);
  // Slow transport: ready on about three cycles in four
  always @(posedge mclk) tape_ready <= stall[0] | stall[1];
  // Report the word that the coming edge takes
  always @(negedge mclk) begin
    obs_valid <= tape_valid && tape_ready;
    obs_word <= {tape_last, tape_data};
  end
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  import trbf_pkg::*;
  localparam int unsigned BL = 16;
  logic       mclk, resetn, reg_write, reg_read, char_valid, char_ready;
  logic       tape_valid, tape_ready, tape_last, obs_valid, continuous_block_format;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, char_data, tape_data, stall;
  logic [8:0] obs_word, want, exp_q[$];
  logic [31:0] seed = 32'h10;
  int         n_mismatch, samples_checked, cnt, blocks, opt;
  int         opts[5] = '{0, 0, 1, 2, 2};
  trbf_framer #(.BLOCK_LEN(BL), .DEPTH(16)) dut (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .char_valid(char_valid), .char_ready(char_ready),
    .char_data(char_data), .tape_valid(tape_valid), .tape_ready(tape_ready),
    .tape_data(tape_data), .tape_last(tape_last));
  trbf_tape_model tape (.mclk(mclk), .stall(stall), .tape_valid(tape_valid),
    .tape_ready(tape_ready), .tape_data(tape_data), .tape_last(tape_last),
    .obs_valid(obs_valid), .obs_word(obs_word));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] exp_v);
    samples_checked++;
    if (seen !== exp_v) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp_v);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp_v);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(negedge mclk);
    check({1'b0, reg_rdata}, {1'b0, exp_v});
    @(posedge mclk);
  endtask
  // Hand one character over, then update the reference model
  task automatic put(input logic [7:0] c);
    int k = 0;
    logic t;
    char_valid <= 1'b1;
    char_data <= c;
    @(negedge mclk);
    while (char_ready !== 1'b1 && k < 400) begin
      @(negedge mclk);
      k++;
    end
    check({8'h00, k < 400}, 9'h001);
    @(posedge mclk);
    char_valid <= 1'b0;
    t = continuous_block_format ? (opt == 1 && c[6:0] == CHAR_ETX) : (c[6:0] == CHAR_CR);
    cnt++;
    exp_q.push_back({t || cnt == BL, (t || (continuous_block_format && opt == 2)) ? c : {1'b0, c[6:0]}});
    if (t || cnt == BL) begin
      cnt = 0;
      blocks++;
    end
    @(posedge mclk);
  endtask
  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Random stall pattern for the transport
  always @(posedge mclk) stall <= 8'(xs());
  // Compare every word taken by the transport
  always @(posedge mclk) begin
    if (obs_valid === 1'b1) begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 9'bx;
      check(obs_word, want);
    end
  end
  // Watchdog
  initial begin
    #2000000;
    check(9'h000, 9'h001);
    complete_run();
  end
  // Main sequence
  initial begin
    {resetn, reg_write, reg_read, char_valid, reg_addr, reg_wdata, char_data} = '0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(REG_STATUS, 8'h01);
    rd(4'hF, 8'h00);
    char_valid <= 1'b1;
    repeat (6) @(posedge mclk);
    char_valid <= 1'b0;
    @(posedge mclk);
    for (int m = 0; m < 5; m++) begin
      continuous_block_format = m > 0 && m < 4;
      opt = opts[m];
      wr(REG_CONTROL, {4'h0, 1'b1, 2'(opt), continuous_block_format});
      rd(REG_CONTROL, {4'h0, 1'b1, 2'(opt), continuous_block_format});
      for (int i = 0; i < 40; i++) begin
        put((i % 5 == 4) ? ((i % 10 == 4) ? 8'h8D : 8'h83) : 8'(xs()));
      end
      while (cnt != 0) put(8'h41);
      repeat (3000) if (exp_q.size() != 0) @(posedge mclk);
      repeat (4) @(posedge mclk);
      check({8'h00, exp_q.size() == 0}, 9'h001);
      rd(REG_COUNT, 8'h00);
      rd(REG_BLOCKS, 8'(blocks));
    end
    wr(REG_CONTROL, 8'h0F);
    rd(REG_CONTROL, 8'h09);
    complete_run();
  end
endmodule
